// ---- logic/ddr_pwr_pkg.sv ----
/*
  Constants for the DDR2 self-refresh, reset and init block: register map,
  field positions, reset values, timing counts, FSM states, commands.
  Assumes a 10 MHz core clock and a 32-bit AHB-Lite register port.
*/
package ddr_pwr_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_BANK_CFG = 8'h08;
  localparam logic [7:0] OFS_REF_CTRL = 8'h0C;
  localparam logic [7:0] OFS_TIM1 = 8'h10;
  localparam logic [7:0] OFS_TIM2 = 8'h14;
  localparam logic [7:0] OFS_CAL_CTRL = 8'h20;
  localparam logic [7:0] OFS_CAL_RES = 8'h24;
  localparam logic [7:0] OFS_CAL_EN = 8'h28;

  // ==========================================================
  // field positions
  localparam int SELFREF_BIT = 31;
  localparam int RR_LSB = 0;
  localparam int CASLAT_LSB = 9;
  localparam int DRIVE_BIT = 18;
  localparam int TWR_LSB = 0;
  localparam int TCKE_LSB = 0;
  localparam int TSXRD_LSB = 8;
  localparam int TSXNR_LSB = 16;
  localparam int CAL_START_BIT = 15;
  localparam int CAL_ENA_BIT = 13;
  localparam int CAL_CODE_W = 10;

  // ==========================================================
  // values after reset
  localparam logic [31:0] REF_CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] BANK_CFG_RST = 32'h0000_0632;
  localparam logic [31:0] TIM1_RST = 32'h0000_0002;
  localparam logic [31:0] TIM2_RST = 32'h0014_0C03;

  // ==========================================================
  // memory address images for precharge-all and mode register writes
  localparam logic [12:0] EMRS1_BASE = 13'h0404;
  localparam logic [12:0] PRE_ALL_ADDR = 13'h0400;
  localparam logic [2:0] BURST_LEN8 = 3'h3;

  // ==========================================================
  // calibration wait: 33 calibration clocks at 13.5 MHz, rounded up
  localparam int CORE_PERIOD_NS = 100;
  localparam int CAL_MIN_CLKS = 33;
  localparam int CAL_CLK_KHZ = 13500;
  localparam int CAL_TIME_NS = (CAL_MIN_CLKS * 1000000 + CAL_CLK_KHZ - 1) / CAL_CLK_KHZ;
  localparam int CAL_CYC = (CAL_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // ==========================================================
  // control states, gray along the init path into ST_IDLE and from ST_SR_PRE to ST_SR_EXIT
  typedef enum logic [3:0] {
    ST_INIT_PRE = 4'h0,
    ST_INIT_EMRS2 = 4'h1,
    ST_INIT_EMRS3 = 4'h3,
    ST_INIT_EMRS1 = 4'h2,
    ST_INIT_MRS = 4'h6,
    ST_INIT_REF = 4'h7,
    ST_IDLE = 4'h5,
    ST_ACCESS = 4'h4,
    ST_SR_PRE = 4'hC,
    ST_SR_ENTER = 4'hD,
    ST_SR_HOLD = 4'hF,
    ST_SR_EXIT = 4'hE
  } state_e;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_MRS = 3'h1,
    CMD_PRE = 3'h2,
    CMD_REF = 3'h3,
    CMD_SELF = 3'h4,
    CMD_RD = 3'h5,
    CMD_WR = 3'h6
  } cmd_e;

endpackage

// ---- logic/sync_edge.sv ----
/*
  Two-flop synchroniser per bit with a rising-edge pulse behind it.
  Assumes inputs come from outside the core clock domain.
*/
`timescale 1ns/100ps
module sync_edge #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  // ==========================================================
  // per-bit chain; the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta;
      logic stage;
      logic prev;
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta <= 1'b0;
          stage <= 1'b0;
          prev <= 1'b0;
        end
        else
        begin
          meta <= async_in[i];
          stage <= meta;
          prev <= stage;
        end
      end
      assign level[i] = stage;
      assign rise[i] = stage & ~prev; // edge seen on the stable copy only
    end
  endgenerate

endmodule

// ---- logic/ddr2_selfrefresh_reset_init.sv ----
/*
  DDR2 controller power-state and bring-up core: self-refresh entry and
  exit, two resets, impedance calibration registers, automatic init of
  the mode registers, refresh counters and a one-deep access slot.
  Assumes an AHB-Lite master on core_clk and a slower memory clock pin
  whose rising edges pace every memory command.
*/
`timescale 1ns/100ps
module ddr2_selfrefresh_reset_init
  import ddr_pwr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic state_machine_reset_n,
  input wire logic memory_side_clock,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic acc_req,
  input wire logic acc_read,
  input wire logic [12:0] acc_addr,
  output logic acc_busy,
  output logic acc_done,
  input wire logic [CAL_CODE_W-1:0] imp_code_in,
  output logic [CAL_CODE_W-1:0] imp_code,
  output logic imp_cal_en,
  output logic [2:0] mem_cmd,
  output logic [1:0] mem_ba,
  output logic [12:0] mem_addr,
  output logic mem_cke
);

  // ==========================================================
  // pin synchronisers: memory clock, state-machine reset, cal code
  logic [CAL_CODE_W+1:0] sync_lvl;
  logic [CAL_CODE_W+1:0] sync_rise;
  logic tick;
  logic sm_run;

  sync_edge #(.W(CAL_CODE_W + 2)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({imp_code_in, state_machine_reset_n, memory_side_clock}),
    .level(sync_lvl),
    .rise(sync_rise)
  );
  assign tick = sync_rise[0];
  assign sm_run = sync_lvl[1];

  // ==========================================================
  // register file and bus state
  logic [31:0] ref_ctrl, bank_cfg, tim1, tim2, cal_ctrl;
  logic [CAL_CODE_W-1:0] cal_res;
  logic cal_acc_en;
  logic [7:0] cal_cnt;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic [31:0] next_ref_ctrl, next_bank_cfg, next_tim1, next_tim2, next_cal_ctrl;
  logic [CAL_CODE_W-1:0] next_cal_res;
  logic next_cal_acc_en;
  logic [7:0] next_cal_cnt;
  logic next_dp_wr;
  logic [7:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic bank_wr;

  // ==========================================================
  // control state
  state_e state, next_state;
  logic [8:0] cnt, next_cnt;
  logic pend, next_pend, pend_read, next_pend_read;
  logic [12:0] pend_addr, next_pend_addr;
  logic init_req, next_init_req;
  logic [15:0] ivl, next_ivl;
  logic [3:0] backlog, next_backlog;
  logic [2:0] next_cmd;
  logic [1:0] next_ba;
  logic [12:0] next_addr;
  logic next_cke, next_done;
  logic in_init;
  logic selfref_bit;
  logic [8:0] t_cke, exit_to_nonread_delay, exit_to_read_delay;

  assign selfref_bit = ref_ctrl[SELFREF_BIT];
  assign t_cke = {4'h0, tim2[TCKE_LSB +: 5]};
  assign exit_to_read_delay = {1'b0, tim2[TSXRD_LSB +: 8]};
  assign exit_to_nonread_delay = {2'h0, tim2[TSXNR_LSB +: 7]};
  assign in_init = (state == ST_INIT_PRE) || (state == ST_INIT_EMRS2) ||
                   (state == ST_INIT_EMRS3) || (state == ST_INIT_EMRS1) ||
                   (state == ST_INIT_MRS) || (state == ST_INIT_REF);

  // write recovery code clamped to 2..6
  function automatic logic [2:0] wr_code(input logic [2:0] f);
    logic [3:0] v;
    v = {1'b0, f} + 4'h1;
    if (v < 4'h2)
      return 3'h2;
    else if (v > 4'h6)
      return 3'h6;
    else
      return v[2:0];
  endfunction

  // CAS latency clamped to 2..5
  function automatic logic [2:0] cl_code(input logic [2:0] f);
    if (f < 3'h2)
      return 3'h2;
    else if (f > 3'h5)
      return 3'h5;
    else
      return f;
  endfunction

  // ==========================================================
  // bus slave: zero wait, read data registered at the address phase
  always_comb
  begin
    next_ref_ctrl = ref_ctrl;
    next_bank_cfg = bank_cfg;
    next_tim1 = tim1;
    next_tim2 = tim2;
    next_cal_ctrl = cal_ctrl;
    next_cal_res = cal_res;
    next_cal_acc_en = cal_acc_en;
    next_cal_cnt = cal_cnt;
    next_dp_wr = hsel && hready && htrans[1] && hwrite;
    next_dp_addr = haddr[7:0];
    next_hrdata = hrdata;
    bank_wr = 1'b0;
    // calibration counts down, then the pad code is captured
    if (cal_cnt != 8'h00)
    begin
      next_cal_cnt = cal_cnt - 8'h01;
      if (cal_cnt == 8'h01)
        next_cal_res = sync_lvl[CAL_CODE_W+1:2];
    end
    if (dp_wr)
    begin
      unique case (dp_addr)
        OFS_REF_CTRL: next_ref_ctrl = hwdata;
        OFS_BANK_CFG:
        begin
          next_bank_cfg = hwdata;
          bank_wr = 1'b1;
        end
        OFS_TIM1: next_tim1 = hwdata;
        OFS_TIM2: next_tim2 = hwdata;
        OFS_CAL_CTRL:
        begin
          next_cal_ctrl = hwdata;
          // a fresh start bit with enable set launches calibration
          if (hwdata[CAL_START_BIT] && hwdata[CAL_ENA_BIT] && !cal_ctrl[CAL_START_BIT])
            next_cal_cnt = 8'(CAL_CYC);
        end
        OFS_CAL_EN: next_cal_acc_en = hwdata[0];
        default: ;
      endcase
    end
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        OFS_STATUS: next_hrdata = {20'h0, backlog, (cal_cnt != 8'h00), !in_init,
                                   mem_cke, pend, state};
        OFS_REF_CTRL: next_hrdata = ref_ctrl;
        OFS_BANK_CFG: next_hrdata = bank_cfg;
        OFS_TIM1: next_hrdata = tim1;
        OFS_TIM2: next_hrdata = tim2;
        OFS_CAL_CTRL: next_hrdata = cal_ctrl;
        // result hidden unless access is enabled
        OFS_CAL_RES: next_hrdata = cal_acc_en ? {22'h0, cal_res} : 32'h0;
        OFS_CAL_EN: next_hrdata = {31'h0, cal_acc_en};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // only the module reset reaches the registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_ctrl <= REF_CTRL_RST;
      bank_cfg <= BANK_CFG_RST;
      tim1 <= TIM1_RST;
      tim2 <= TIM2_RST;
      cal_ctrl <= 32'h0;
      cal_res <= '0;
      cal_acc_en <= 1'b0;
      cal_cnt <= 8'h00;
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      imp_code <= '0;
      imp_cal_en <= 1'b0;
    end
    else
    begin
      ref_ctrl <= next_ref_ctrl;
      bank_cfg <= next_bank_cfg;
      tim1 <= next_tim1;
      tim2 <= next_tim2;
      cal_ctrl <= next_cal_ctrl;
      cal_res <= next_cal_res;
      cal_acc_en <= next_cal_acc_en;
      cal_cnt <= next_cal_cnt;
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      imp_code <= next_cal_ctrl[CAL_CODE_W-1:0];
      imp_cal_en <= next_cal_ctrl[CAL_ENA_BIT];
    end
  end

  // ==========================================================
  // control FSM, refresh counters and access slot
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_pend = pend;
    next_pend_read = pend_read;
    next_pend_addr = pend_addr;
    next_init_req = init_req || bank_wr; // set wins over the ST_INIT_PRE clear below, not over the state-machine reset
    next_ivl = ivl;
    next_backlog = backlog;
    next_cmd = tick ? CMD_NOP : mem_cmd;
    next_ba = mem_ba;
    next_addr = mem_addr;
    next_cke = mem_cke;
    next_done = 1'b0;
    if (acc_req && !pend)
    begin
      next_pend = 1'b1;
      next_pend_read = acc_read;
      next_pend_addr = acc_addr;
    end
    // counters frozen while the memory refreshes itself
    if (state != ST_SR_HOLD)
    begin
      if (ivl == 16'h0)
      begin
        next_ivl = ref_ctrl[RR_LSB +: 16];
        if (backlog != 4'hF)
          next_backlog = backlog + 4'h1;
      end
      else
        next_ivl = ivl - 16'h1;
    end
    if (tick)
    begin
      unique case (state)
        ST_INIT_PRE:
        begin
          next_cke = 1'b1;
          next_cmd = CMD_PRE;
          next_addr = PRE_ALL_ADDR;
          next_init_req = bank_wr;
          next_state = ST_INIT_EMRS2;
        end
        ST_INIT_EMRS2:
        begin
          next_cmd = CMD_MRS;
          next_ba = 2'h2;
          next_addr = 13'h0;
          next_state = ST_INIT_EMRS3;
        end
        ST_INIT_EMRS3:
        begin
          next_cmd = CMD_MRS;
          next_ba = 2'h3;
          next_addr = 13'h0;
          next_state = ST_INIT_EMRS1;
        end
        ST_INIT_EMRS1:
        begin
          next_cmd = CMD_MRS;
          next_ba = 2'h1;
          next_addr = EMRS1_BASE | {11'h0, bank_cfg[DRIVE_BIT], 1'b0};
          next_state = ST_INIT_MRS;
        end
        ST_INIT_MRS:
        begin
          next_cmd = CMD_MRS;
          next_ba = 2'h0;
          // fast exit, no dll reset, normal, sequential, burst of eight
          next_addr = {1'b0, wr_code(tim1[TWR_LSB +: 3]), 2'b00,
                       cl_code(bank_cfg[CASLAT_LSB +: 3]), 1'b0, BURST_LEN8};
          next_state = ST_INIT_REF;
        end
        ST_INIT_REF:
        begin
          next_cmd = CMD_REF;
          next_state = ST_IDLE;
        end
        ST_IDLE:
        begin
          // queued access goes before a config-triggered init
          if (pend)
            next_state = ST_ACCESS;
          else if (init_req)
            next_state = ST_INIT_PRE;
          else if (backlog != 4'h0)
          begin
            next_cmd = CMD_REF;
            next_backlog = next_backlog - 4'h1;
          end
          else if (selfref_bit)
            next_state = ST_SR_PRE;
        end
        ST_ACCESS:
        begin
          next_cmd = pend_read ? CMD_RD : CMD_WR;
          next_addr = pend_addr;
          next_pend = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
        ST_SR_PRE:
        begin
          next_cmd = CMD_PRE;
          next_addr = PRE_ALL_ADDR;
          next_state = ST_SR_ENTER;
        end
        ST_SR_ENTER:
        begin
          next_cmd = CMD_SELF;
          next_cke = 1'b0;
          next_cnt = 9'h0;
          next_state = ST_SR_HOLD;
        end
        ST_SR_HOLD:
        begin
          if (cnt != 9'h1FF)
            next_cnt = cnt + 9'h1;
          // wake only once the minimum clock-enable time has run
          if ((cnt > t_cke) && (pend || !selfref_bit))
          begin
            next_cke = 1'b1;
            next_cnt = 9'h0;
            next_state = ST_SR_EXIT;
          end
        end
        ST_SR_EXIT:
        begin
          if (cnt != 9'h1FF)
            next_cnt = cnt + 9'h1;
          if (pend && (pend_read ? (cnt > exit_to_read_delay) : (cnt > exit_to_nonread_delay)))
            next_state = ST_ACCESS;
          else if (!pend && (cnt > exit_to_nonread_delay))
            next_state = ST_IDLE;
        end
        default: next_state = ST_INIT_PRE;
      endcase
    end
    // state-machine reset: queue and counters dropped, registers untouched
    if (!sm_run)
    begin
      next_state = ST_INIT_PRE;
      next_cnt = 9'h0;
      next_pend = 1'b0;
      next_init_req = 1'b0;
      next_ivl = ref_ctrl[RR_LSB +: 16];
      next_backlog = 4'h0;
      next_cmd = CMD_NOP;
      next_cke = 1'b0;
      next_done = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_INIT_PRE;
      cnt <= 9'h0;
      pend <= 1'b0;
      pend_read <= 1'b0;
      pend_addr <= 13'h0;
      init_req <= 1'b0;
      ivl <= 16'h0;
      backlog <= 4'h0;
      mem_cmd <= CMD_NOP;
      mem_ba <= 2'h0;
      mem_addr <= 13'h0;
      mem_cke <= 1'b0;
      acc_done <= 1'b0;
      acc_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      pend <= next_pend;
      pend_read <= next_pend_read;
      pend_addr <= next_pend_addr;
      init_req <= next_init_req;
      ivl <= next_ivl;
      backlog <= next_backlog;
      mem_cmd <= next_cmd;
      mem_ba <= next_ba;
      mem_addr <= next_addr;
      mem_cke <= next_cke;
      acc_done <= next_done;
      acc_busy <= next_pend;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_wake;
    (state == ST_SR_HOLD) ##1 (state == ST_SR_EXIT);
  endsequence

  property p_sr_entry_clean;
    (state == ST_IDLE && next_state == ST_SR_PRE) |-> (!pend && backlog == 4'h0);
  endproperty
  a_sr_entry_clean: assert property (p_sr_entry_clean) else $error("self-refresh with work pending");

  property p_self_cmd;
    (state == ST_SR_ENTER && tick && sm_run) |=> (mem_cmd == CMD_SELF && !mem_cke);
  endproperty
  a_self_cmd: assert property (p_self_cmd) else $error("self-refresh command missing");

  property p_wake_on_clear;
    (state == ST_SR_HOLD && tick && sm_run && cnt > t_cke && !selfref_bit) |=> mem_cke;
  endproperty
  a_wake_on_clear: assert property (p_wake_on_clear) else $error("no wake after bit cleared");

  property p_wake_min;
    s_wake |-> $past(cnt) > t_cke;
  endproperty
  a_wake_min: assert property (p_wake_min) else $error("woke before clock-enable time");

  property p_exit_read;
    (state == ST_SR_EXIT && next_state == ST_ACCESS && pend_read) |-> cnt > exit_to_read_delay;
  endproperty
  a_exit_read: assert property (p_exit_read) else $error("read too soon after exit");

  property p_counters_hold;
    (state == ST_SR_HOLD && sm_run) |=> (backlog == $past(backlog) && ivl == $past(ivl));
  endproperty
  a_counters_hold: assert property (p_counters_hold) else $error("refresh counters moved");

  property p_cal_hidden;
    (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFS_CAL_RES && !cal_acc_en)
      |=> hrdata == 32'h0;
  endproperty
  a_cal_hidden: assert property (p_cal_hidden) else $error("result read while disabled");

  property p_mrs_image;
    (mem_cmd == CMD_MRS && mem_ba == 2'h0) |->
      (mem_addr[12] == 1'b0 && mem_addr[8:7] == 2'b00 && mem_addr[3:0] == 4'h3 &&
       mem_addr[11:9] >= 3'h2 && mem_addr[11:9] <= 3'h6 &&
       mem_addr[6:4] >= 3'h2 && mem_addr[6:4] <= 3'h5);
  endproperty
  a_mrs_image: assert property (p_mrs_image) else $error("bad mode register image");

  property p_no_access_in_init;
    // a command stands a whole memory cycle, so only its first core cycle is checked
    ((mem_cmd == CMD_RD || mem_cmd == CMD_WR) && $changed(mem_cmd)) |->
      $past(state) == ST_ACCESS;
  endproperty
  a_no_access_in_init: assert property (p_no_access_in_init) else $error("access during init");

  property p_sm_reset;
    !sm_run |=> (state == ST_INIT_PRE && !pend);
  endproperty
  a_sm_reset: assert property (p_sm_reset) else $error("state reset not applied");

endmodule

// ---- test/ddr2_mem_model.sv ----
/*
  DDR2 memory stand-in: keeps its mode registers, counts autorefreshes and
  tracks self-refresh. Assumes each command stands for one memory clock
  and is sampled on that clock's rising edge.
*/
`timescale 1ns/100ps
module ddr2_mem_model
  import ddr_pwr_pkg::*;
(
  input wire logic memory_side_clock,
  input wire logic [2:0] mem_cmd,
  input wire logic [1:0] mem_ba,
  input wire logic [12:0] mem_addr,
  input wire logic mem_cke,
  output logic [12:0] mr [4],
  output logic in_self,
  output int n_ref
);
  // ==========================================================
  // command decode
  initial
  begin
    in_self = 1'b0;
    n_ref = 0;
  end

  // mode and refresh commands count only with clock enable high, self-refresh entry only with it low; self-refresh ends on its rise
  always @(posedge memory_side_clock)
  begin
    if (mem_cke && mem_cmd == CMD_MRS)
      mr[mem_ba] <= mem_addr;
    if (mem_cke && mem_cmd == CMD_REF)
      n_ref <= n_ref + 1;
    if (!mem_cke && mem_cmd == CMD_SELF)
      in_self <= 1'b1;
    else if (mem_cke)
      in_self <= 1'b0;
  end
endmodule

// ---- test/ddr2_selfrefresh_reset_init_bench.sv ----
/*
  Bench for the self-refresh, reset and init block: AHB-Lite register
  tasks, an access driver and hand-written scenarios.
  Assumes the memory stand-in model and a 10 MHz core clock.
*/
`timescale 1ns/100ps
module ddr2_selfrefresh_reset_init_bench;
  import ddr_pwr_pkg::*;
  logic core_clk = 0, nrst = 0, state_machine_reset_n = 1, memory_side_clock = 0;
  logic hsel = 0, hwrite = 0, acc_req = 0, acc_read = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic hreadyout, hresp, acc_busy, acc_done, imp_cal_en, mem_cke, in_self;
  logic [9:0] imp_code;
  logic [2:0] mem_cmd;
  logic [1:0] mem_ba;
  logic [12:0] mem_addr, mr [4];
  int num_errors = 0, checks_done = 0, n_ref, lo, hi, n0;

  // ==========================================================
  // clocks: both kept running, memory clock on its own phase
  always #50 core_clk = ~core_clk;
  initial
  begin
    #137;
    forever #400 memory_side_clock = ~memory_side_clock;
  end

  ddr2_selfrefresh_reset_init i_ddr2_selfrefresh_reset_init (.core_clk, .nrst,
    .state_machine_reset_n, .memory_side_clock, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .acc_req,
    .acc_read, .acc_addr(13'h0123), .acc_busy, .acc_done, .imp_code_in(10'h2A5),
    .imp_code, .imp_cal_en, .mem_cmd, .mem_ba, .mem_addr, .mem_cke);
  ddr2_mem_model i_ddr2_mem_model (.memory_side_clock, .mem_cmd, .mem_ba, .mem_addr,
    .mem_cke, .mr, .in_self, .n_ref);

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer; read data taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask

  // sampled at falling edges so registered outputs have settled
  task automatic until_self(input logic v);
    for (int i = 0; i < 3000 && in_self !== v; i++) @(negedge core_clk);
    chk("in_self", v, in_self);
  endtask

  // counts cycles with clock enable low and high until the access issues
  task automatic acc(input logic r);
    lo = 0;
    hi = 0;
    @(posedge core_clk);
    acc_req <= 1;
    acc_read <= r;
    @(posedge core_clk);
    acc_req <= 0;
    while (acc_done !== 1'b1 && lo + hi < 3000)
    begin
      @(negedge core_clk);
      if (mem_cke === 1'b1)
        hi++;
      else
        lo++;
    end
    chk("acc_cmd", r ? CMD_RD : CMD_WR, mem_cmd);
    chk("acc_addr", 13'h0123, mem_addr);
  endtask

  task automatic wait_init;
    for (int i = 0; i < 800 && n_ref == n0; i++) @(negedge core_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_init;
    acc(1'b0);
    chk("ref_first", 1, n_ref > 0);
    chk("mode", 13'h0633, mr[0]);
    chk("emr1", EMRS1_BASE, mr[1]);
    chk("emr2", 0, mr[2]);
    chk("emr3", 0, mr[3]);
    bus(0, OFS_STATUS, 0);
    chk("init_done", 1, rd[6]);
    $display("test init done");
  endtask

  // config write lands while an access is held in the slot
  task automatic t_cfg;
    bus(1, OFS_TIM1, 32'h5);
    n0 = n_ref;
    fork
      acc(1'b1);
      bus(1, OFS_BANK_CFG, 32'h0004_0A32);
    join
    chk("mode_old", 13'h0633, mr[0]);
    wait_init;
    chk("mode_new", 13'h0C53, mr[0]);
    chk("emr1_new", EMRS1_BASE | 13'h2, mr[1]);
    $display("test cfg done");
  endtask

  task automatic t_self;
    bus(1, OFS_REF_CTRL, 32'h8000_0100);
    until_self(1);
    chk("cke_low", 0, mem_cke);
    acc(1'b1);
    chk("cke_hold", 1, lo >= 28);
    // read delay field 12, plus one memory cycle of eight core cycles
    chk("rd_wait", 1, hi > 104);
    until_self(1);
    bus(0, OFS_STATUS, 0);
    chk("backlog0", 0, rd[11:8]);
    repeat (600) @(posedge core_clk);
    bus(0, OFS_STATUS, 0);
    chk("backlog_held", 0, rd[11:8]);
    acc(1'b0);
    chk("wr_wait", 1, hi > 168);
    until_self(1);
    bus(1, OFS_REF_CTRL, 32'h100);
    until_self(0);
    chk("cke_up", 1, mem_cke);
    $display("test self-refresh done");
  endtask

  task automatic t_cal;
    bus(1, OFS_CAL_CTRL, 32'h0000_201F);
    bus(1, OFS_CAL_CTRL, 32'h0000_A01F);
    repeat (CAL_CYC + 5) @(posedge core_clk);
    bus(0, OFS_CAL_RES, 0);
    chk("res_locked", 0, rd);
    bus(1, OFS_CAL_EN, 1);
    bus(0, OFS_CAL_RES, 0);
    chk("res", 10'h2A5, rd);
    bus(1, OFS_CAL_CTRL, 32'h0000_A000 | rd);
    @(negedge core_clk);
    chk("code", 10'h2A5, imp_code);
    chk("cal_en", 1, imp_cal_en);
    bus(0, 8'h3C, 0);
    chk("unmapped", 0, rd);
    $display("test calibration done");
  endtask

  // no bus traffic while either reset is held
  task automatic t_rst;
    @(posedge core_clk);
    acc_req <= 1;
    @(posedge core_clk);
    acc_req <= 0;
    state_machine_reset_n <= 0;
    n0 = n_ref;
    repeat (5) @(posedge core_clk);
    state_machine_reset_n <= 1;
    @(negedge core_clk);
    chk("slot_dropped", 0, acc_busy);
    wait_init;
    chk("init_rerun", 1, n_ref > n0);
    bus(0, OFS_TIM1, 0);
    chk("tim1_kept", 32'h5, rd);
    nrst <= 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    repeat (2) @(posedge core_clk);
    bus(0, OFS_TIM1, 0);
    chk("tim1_rst", TIM1_RST, rd);
    bus(0, OFS_BANK_CFG, 0);
    chk("bank_rst", BANK_CFG_RST, rd);
    $display("test resets done");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge core_clk);
    nrst <= 1;
    repeat (2) @(posedge core_clk);
    t_init;
    t_cfg;
    t_self;
    t_cal;
    t_rst;
    results;
  end

  // a hang anywhere ends the run as a failure
  initial
  begin
    #8000000;
    num_errors++;
    results;
  end
endmodule
